//--- rtl/eer_consts.vh
`ifndef EER_CONSTS_VH
`define EER_CONSTS_VH
// device type code; the value is arbitrary
`define EER_TYPE_CODE 4'h5
`define EER_ERASED_BYTE 8'hFF
`define EER_PROG_CYCLES 16'h0064
`endif

//--- rtl/eer_mem.v
`timescale 1ns/1ps
module eer_mem #(
   parameter AW = 16,
   parameter DW = 8
) (
   input wire clk,
   input wire we,
   input wire [AW-1:0] waddr,
   input wire [DW-1:0] wdata,
   input wire [AW-1:0] raddr,
   output reg [DW-1:0] rdata
);
`include "eer_consts.vh"
   reg [DW-1:0] mem [0:(1<<AW)-1];
   integer i;
   // erased delivery state [R16]
   initial begin
      for (i = 0; i < (1<<AW); i = i + 1) begin
         mem[i] = `EER_ERASED_BYTE;
      end
   end
   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule // eer_mem

//--- rtl/eer_top.v
`timescale 1ns/1ps
// Notes on behaviour
// R1 - during program cycle detach from bus and commit latched data
// R2 - matching select while busy gets no acknowledge
// R3 - after program cycle, acknowledge select and run instruction
// R4 - master polls with start plus select until acknowledged
// R5 - master repeats same seven select bits after restart
// R6 - reads ignore write protect level
// R7 - each completed read byte advances address counter by one
// R8 - random read: dummy write of address, restart, read select
// R9 - after read select, shift out byte at loaded address
// R10 - master ends single read with no acknowledge and stop
// R11 - current address read outputs byte at counter then increments
// R12 - master acknowledge continues with next consecutive byte
// R13 - master ends sequential read with no acknowledge and stop
// R14 - counter wraps from top address to zero
// R15 - no acknowledge in ninth slot ends transmission, standby
// R16 - array starts with every byte reading all ones
// R17 - select holds type code and strap bits; mismatch goes standby
// R18 - eighth select bit is direction, one read zero write
// R19 - sixteen-bit address sent high byte first
// R20 - sample on scl rise; sda change with scl high is start/stop
// R21 - program cycle length is a parameter in clock cycles
// R22 - system clock oversamples scl and sda synchronously
module eer_top #(
   parameter AW = 16,
   parameter PROG_CYCLES = `EER_PROG_CYCLES
) (
   input wire SYS_CLK,
   input wire RST_B,
   input wire SCL,
   input wire SDA_IN,
   output wire SDA_OUT,
   output wire SDA_OE_B,
   input wire WRITE_PROTECT_INPUT,
   input wire CHIP_SELECT_STRAP_0,
   input wire CHIP_SELECT_STRAP_1,
   input wire CHIP_SELECT_STRAP_2,
   output wire BUSY
);
`include "eer_consts.vh"
   reg [1:0] scl_s_q, sda_s_q;
   reg [1:0] wc_s_q;
   reg [1:0] cs0_s_q, cs1_s_q, cs2_s_q;
   localparam ST_IDLE = 3'h0;
   localparam ST_DSEL = 3'h1;
   localparam ST_ADDR = 3'h2;
   localparam ST_WDAT = 3'h3;
   localparam ST_RDAT = 3'h4;
   localparam ST_RACK = 3'h5;
   localparam ST_SACK = 3'h6;
   reg scl_q, sda_q;
   reg [2:0] st_q;
   reg [3:0] bit_q;
   reg [7:0] sh_q;
   reg [7:0] tx_q;
   reg drive_q;
   reg rw_q;
   reg byte_hi_q;
   reg [1:0] addr_cnt_q;
   reg [AW-1:0] ctr_q;
   reg [AW-1:0] wadr_q;
   reg [7:0] wdat_q;
   reg pend_q;
   reg wp_q;
   reg [15:0] prog_q;
   reg mem_we_q;
   wire [7:0] rdata;
   wire scl_rise, scl_fall, start_c, stop_c, busy;
   wire [2:0] straps;
   // sync pins; logic reads second stage, plus scl_q and sda_q one clock later [R22]
   always @(posedge SYS_CLK) begin
      scl_s_q <= {scl_s_q[0], SCL};
      sda_s_q <= {sda_s_q[0], SDA_IN};
      wc_s_q <= {wc_s_q[0], WRITE_PROTECT_INPUT};
      cs0_s_q <= {cs0_s_q[0], CHIP_SELECT_STRAP_0};
      cs1_s_q <= {cs1_s_q[0], CHIP_SELECT_STRAP_1};
      cs2_s_q <= {cs2_s_q[0], CHIP_SELECT_STRAP_2};
      scl_q <= scl_s_q[1];
      sda_q <= sda_s_q[1];
   end
   assign straps = {cs2_s_q[1], cs1_s_q[1], cs0_s_q[1]};
   assign scl_rise = scl_s_q[1] & ~scl_q;
   assign scl_fall = ~scl_s_q[1] & scl_q;
   // sda edge with scl high is a start or stop [R20]
   assign start_c = scl_q & scl_s_q[1] & sda_q & ~sda_s_q[1];
   assign stop_c = scl_q & scl_s_q[1] & ~sda_q & sda_s_q[1];
   assign busy = (prog_q != 16'h0000);
   assign BUSY = busy;
   // open drain: drive low only when drive_q; released while busy [R1]
   assign SDA_OUT = 1'b0;
   assign SDA_OE_B = ~(drive_q & ~busy);

   eer_mem #(.AW(AW), .DW(8)) u_mem (
      .clk(SYS_CLK),
      .we(mem_we_q),
      .waddr(wadr_q),
      .wdata(wdat_q),
      .raddr(ctr_q),
      .rdata(rdata)
   );

   // program cycle length in clock cycles [R21]
   always @(posedge SYS_CLK) begin
      if (!RST_B) begin
         prog_q <= 16'h0000;
         mem_we_q <= 1'b0;
      end else begin
         mem_we_q <= 1'b0;
         if (stop_c && pend_q && !busy) begin
            prog_q <= PROG_CYCLES[15:0];
         end else if (busy) begin
            prog_q <= prog_q - 16'h0001;
            // commit latched byte at end of cycle [R1]
            if (prog_q == 16'h0001) begin
               mem_we_q <= 1'b1;
            end
         end
      end
   end

   always @(posedge SYS_CLK) begin
      if (!RST_B) begin
         st_q <= ST_IDLE;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         tx_q <= 8'h00;
         drive_q <= 1'b0;
         rw_q <= 1'b0;
         byte_hi_q <= 1'b0;
         addr_cnt_q <= 2'h0;
         ctr_q <= {AW{1'b0}};
         wadr_q <= {AW{1'b0}};
         wdat_q <= 8'h00;
         pend_q <= 1'b0;
         wp_q <= 1'b0;
      end else if (mem_we_q) begin
         // counter points past the programmed byte
         ctr_q <= wadr_q + 1'b1;
         pend_q <= 1'b0;
      end else if (busy) begin
         // ignore all bus activity [R1] [R2]
         st_q <= ST_IDLE;
         drive_q <= 1'b0;
      end else if (stop_c) begin
         st_q <= ST_IDLE;
         drive_q <= 1'b0;
      end else if (start_c) begin
         st_q <= ST_DSEL;
         bit_q <= 4'h0;
         drive_q <= 1'b0;
         pend_q <= 1'b0;
         wp_q <= wc_s_q[1];
      end else if (scl_rise) begin
         // shift in on scl rise [R20]
         sh_q <= {sh_q[6:0], sda_q};
         if (st_q == ST_RACK) begin
            if (sda_q) begin
               // no acknowledge: standby [R15]
               st_q <= ST_IDLE;
            end else begin
               // counter already points at the next byte [R12] [R14]
               tx_q <= rdata;
               st_q <= ST_RDAT;
               bit_q <= 4'h0;
            end
         end else if (st_q != ST_IDLE) begin
            bit_q <= bit_q + 4'h1;
         end
      end else if (scl_fall) begin
         case (st_q)
            ST_DSEL, ST_ADDR, ST_WDAT: begin
               if (bit_q == 4'h8) begin
                  drive_q <= 1'b1;
                  bit_q <= 4'h0;
                  if (st_q == ST_DSEL) begin
                     // type code and strap match [R17] [R3]
                     if (sh_q[7:4] != `EER_TYPE_CODE ||
                         sh_q[3:1] != straps) begin
                        drive_q <= 1'b0;
                        st_q <= ST_IDLE;
                     end else begin
                        rw_q <= sh_q[0]; // [R18]
                        byte_hi_q <= 1'b1;
                        addr_cnt_q <= 2'h0;
                        st_q <= ST_SACK;
                     end
                  end else if (st_q == ST_ADDR) begin
                     // high byte first [R19]
                     if (byte_hi_q) begin
                        ctr_q[AW-1:8] <= sh_q[AW-9:0];
                        byte_hi_q <= 1'b0;
                     end else begin
                        ctr_q[7:0] <= sh_q;
                        addr_cnt_q <= 2'h2;
                     end
                     st_q <= ST_SACK;
                  end else begin
                     if (wp_q) begin
                        drive_q <= 1'b0;
                     end else begin
                        wdat_q <= sh_q;
                        wadr_q <= ctr_q;
                        pend_q <= 1'b1;
                     end
                     st_q <= ST_SACK;
                  end
               end
            end
            ST_SACK: begin
               // ack slot done
               bit_q <= 4'h0;
               if (rw_q) begin
                  // read output ignores write protect [R6] [R9] [R11]
                  drive_q <= ~rdata[7];
                  ctr_q <= ctr_q + 1'b1; // [R7]
                  tx_q <= {rdata[6:0], 1'b0};
                  st_q <= ST_RDAT;
               end else if (addr_cnt_q == 2'h2) begin
                  drive_q <= 1'b0;
                  st_q <= ST_WDAT;
               end else begin
                  drive_q <= 1'b0;
                  st_q <= ST_ADDR;
               end
            end
            ST_RDAT: begin
               if (bit_q == 4'h8) begin
                  // release for master acknowledge [R15]
                  drive_q <= 1'b0;
                  st_q <= ST_RACK;
               end else begin
                  // sda only moves while scl is low [R20]
                  drive_q <= ~tx_q[7];
                  tx_q <= {tx_q[6:0], 1'b0};
                  if (bit_q == 4'h0) begin
                     // msb of a follow-on byte; wraps at top [R7] [R14]
                     ctr_q <= ctr_q + 1'b1;
                  end
               end
            end
            default: begin
               drive_q <= 1'b0;
            end
         endcase
      end
   end
endmodule // eer_top

//--- testbench/eer_master.sv
`timescale 1ns/1ps
module eer_master (
   input wire clk,
   input wire sda,
   output reg scl,
   output reg md,
   output reg got,
   output reg [8:0] got_v
);
   initial begin
      scl = 1'b1;
      md = 1'b1;
      got = 1'b0;
      got_v = 9'h000;
   end
   // data moves only in the low phase; scl stands high between frames
   task bit_x(input logic b, output logic r);
      repeat (2) @(posedge clk);
      md <= b;
      repeat (2) @(posedge clk);
      scl <= 1'b1;
      repeat (4) @(posedge clk);
      r = sda;
      scl <= 1'b0;
   endtask
   // a=1,b=0 gives start or restart; a=0,b=1 gives stop
   task cond(input logic a, input logic b);
      repeat (2) @(posedge clk);
      md <= a;
      repeat (2) @(posedge clk);
      scl <= 1'b1;
      repeat (4) @(posedge clk);
      md <= b;
      repeat (4) @(posedge clk);
      if (!b) scl <= 1'b0;
   endtask
   task xfer(input logic rd, input logic [7:0] d, input logic ma);
      logic [7:0] q;
      logic r;
      integer i;
      for (i = 7; i >= 0; i = i - 1) begin
         bit_x(rd ? 1'b1 : d[i], r);
         q[i] = r;
      end
      bit_x(rd ? ma : 1'b1, r);
      got_v <= rd ? {1'b0, q} : {8'h80, r};
      got <= 1'b1;
      @(posedge clk);
      got <= 1'b0;
   endtask
endmodule // eer_master

//--- testbench/eer_properties.sv
`timescale 1ns/1ps
module eer_properties #(parameter PROG_CYCLES = 100) (
   input wire SYS_CLK,
   input wire RST_B,
   input wire SCL,
   input wire SDA_IN,
   input wire SDA_OUT,
   input wire SDA_OE_B,
   input wire WRITE_PROTECT_INPUT,
   input wire CHIP_SELECT_STRAP_0,
   input wire CHIP_SELECT_STRAP_1,
   input wire CHIP_SELECT_STRAP_2,
   input wire BUSY
);
   reg [15:0] run_q;
   // length of the current busy run, zero outside it
   always @(posedge SYS_CLK) begin
      if (BUSY && RST_B) begin
         run_q <= run_q + 16'h0001;
      end else begin
         run_q <= 16'h0000;
      end
   end
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_B);
   property p_out_zero;
      SDA_OUT == 1'b0;
   endproperty
   a_out_zero: assert property (p_out_zero)
      else $error("sda out high");
   property p_busy_quiet;
      BUSY |-> SDA_OE_B;
   endproperty
   a_busy_quiet: assert property (p_busy_quiet)
      else $error("driven busy");
   property p_busy_len;
      $fell(BUSY) |-> run_q == PROG_CYCLES;
   endproperty
   a_busy_len: assert property (p_busy_len)
      else $error("busy length");
   property p_busy_start;
      $rose(BUSY) |-> SCL && SDA_IN;
   endproperty
   a_busy_start: assert property (p_busy_start)
      else $error("busy not at stop");
   property p_edge_low;
      $changed(SDA_OE_B) |-> !$past(SCL);
   endproperty
   a_edge_low: assert property (p_edge_low)
      else $error("sda moved scl high");
   property p_start_free;
      SCL && $past(SCL) && $fell(SDA_IN) |-> SDA_OE_B;
   endproperty
   a_start_free: assert property (p_start_free)
      else $error("held at start");
   property p_stop_free;
      SCL && $rose(SDA_IN) |=> SDA_OE_B [*4];
   endproperty
   a_stop_free: assert property (p_stop_free)
      else $error("held after stop");
   property p_rst_idle;
      $rose(RST_B) |-> SDA_OE_B && !BUSY;
   endproperty
   a_rst_idle: assert property (p_rst_idle)
      else $error("not idle at reset");
endmodule // eer_properties
bind eer_top eer_properties #(.PROG_CYCLES(PROG_CYCLES)) u_props (
   .SYS_CLK(SYS_CLK),
   .RST_B(RST_B),
   .SCL(SCL),
   .SDA_IN(SDA_IN),
   .SDA_OUT(SDA_OUT),
   .SDA_OE_B(SDA_OE_B),
   .WRITE_PROTECT_INPUT(WRITE_PROTECT_INPUT),
   .CHIP_SELECT_STRAP_0(CHIP_SELECT_STRAP_0),
   .CHIP_SELECT_STRAP_1(CHIP_SELECT_STRAP_1),
   .CHIP_SELECT_STRAP_2(CHIP_SELECT_STRAP_2),
   .BUSY(BUSY)
);

//--- testbench/testbench.sv
`timescale 1ns/1ps
`include "eer_consts.vh"
module testbench;
   localparam PROG = 400;
   reg SYS_CLK = 1'b0;
   reg RST_B = 1'b0;
   reg wprot = 1'b0;
   reg [2:0] strap = 3'h0;
   wire scl, md, got, sda, sda_out, sda_oe_b, busy;
   wire [8:0] got_v;
   integer bad_count = 0;
   integer samples_checked = 0;
   integer k;
   logic [8:0] notes [$];
   logic [7:0] mem [logic [15:0]];
   logic [15:0] cnt, a;
   logic [7:0] d;
   always #50 SYS_CLK = ~SYS_CLK;
   assign sda = md & (sda_oe_b | sda_out);
   eer_master m (.clk(SYS_CLK), .sda(sda), .scl(scl), .md(md), .got(got),
      .got_v(got_v));
   eer_top #(.PROG_CYCLES(PROG)) dut (.SYS_CLK(SYS_CLK), .RST_B(RST_B),
      .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE_B(sda_oe_b),
      .WRITE_PROTECT_INPUT(wprot), .CHIP_SELECT_STRAP_0(strap[0]),
      .CHIP_SELECT_STRAP_1(strap[1]), .CHIP_SELECT_STRAP_2(strap[2]),
      .BUSY(busy));
   task check(input logic [8:0] seen, input logic [8:0] exp);
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
         bad_count = bad_count + 1;
         $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
      end
   endtask
   always @(posedge SYS_CLK) begin
      if (got === 1'b1) begin
         check(got_v, notes.pop_front());
      end
   end
   function logic [7:0] rd(input logic [15:0] x);
      rd = mem.exists(x) ? mem[x] : 8'hFF;
   endfunction
   function logic [7:0] sel(input logic rw);
      sel = {`EER_TYPE_CODE, strap, rw};
   endfunction
   task wb(input logic [7:0] v, input logic nk);
      notes.push_back({8'h80, nk});
      m.xfer(1'b0, v, 1'b1);
   endtask
   // ack high: master pulls sda low in the ninth slot
   task rb(input logic ack);
      notes.push_back({1'b0, rd(cnt)});
      cnt = cnt + 16'h0001;
      m.xfer(1'b1, 8'hFF, ~ack);
   endtask
   task seek(input logic [15:0] x);
      m.cond(1'b1, 1'b0);
      wb(sel(1'b0), 1'b0);
      wb(x[15:8], 1'b0);
      wb(x[7:0], 1'b0);
      cnt = x;
      m.cond(1'b1, 1'b0);
      wb(sel(1'b1), 1'b0);
   endtask
   task cur_read;
      m.cond(1'b1, 1'b0);
      wb(sel(1'b1), 1'b0);
      rb(1'b0);
      m.cond(1'b0, 1'b1);
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0 && notes.size() == 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      #3000000;
      bad_count = bad_count + 1;
      tally_and_finish;
   end
   initial begin
      void'($urandom(21716));
      @(posedge SYS_CLK);
      strap <= 3'($urandom);
      repeat (15) @(posedge SYS_CLK);
      RST_B <= 1'b1;
      repeat (4) @(posedge SYS_CLK);
      for (k = 0; k < 3; k = k + 1) begin
         // address zero first, so the wrap read below sees written data
         a = (k == 0) ? 16'h0000 : 16'($urandom);
         d = 8'($urandom);
         wprot <= (k == 2);
         @(posedge SYS_CLK);
         m.cond(1'b1, 1'b0);
         wb(sel(1'b0), 1'b0);
         wb(a[15:8], 1'b0);
         wb(a[7:0], 1'b0);
         wb(d, wprot);
         m.cond(1'b0, 1'b1);
         if (!wprot) begin
            mem[a] = d;
            m.cond(1'b1, 1'b0);
            wb(sel(1'b0), 1'b1);
            m.cond(1'b0, 1'b1);
            repeat (PROG) @(posedge SYS_CLK);
         end
         wprot <= 1'($urandom);
         seek(a);
         rb(1'b1);
         rb(1'b0);
         m.cond(1'b0, 1'b1);
         cur_read;
      end
      seek(16'hFFFE);
      for (k = 0; k < 3; k = k + 1) rb(1'b1);
      rb(1'b0);
      m.cond(1'b0, 1'b1);
      cur_read;
      m.cond(1'b1, 1'b0);
      wb(sel(1'b1) ^ 8'h02, 1'b1);
      m.cond(1'b0, 1'b1);
      cur_read;
      tally_and_finish;
   end
endmodule // testbench
